// ---- logic/monitor_dac_cfg.svh ----
`ifndef MONITOR_DAC_CFG_SVH
`define MONITOR_DAC_CFG_SVH

`define CFG_ADDR_W 12
`define CFG_OFFSET 12'h0F6
`define ADDR_LSB 0
`define ADDR_MSB 13
`define POLARITY_BIT 14
`define EIGHTHS_LSB 15
`define EIGHTHS_MSB 18
`define POW2_LSB 19
`define POW2_MSB 22
`define ADDR_RESET 14'h0000
`define EIGHTHS_RESET 4'h8
`define POW2_RESET 4'h0
`define POLARITY_RESET 1'b0
`define ENUM_MAX 16'h001F
`define VAR_W 16
`define DAC_W 12
`define DAC_FULL 12'hFFF
`define DAC_MID 12'h800

`endif

// ---- logic/monitor_dac_pkg.sv ----
package monitor_dac_pkg;

  typedef struct packed {
    logic [3:0] power_of_two_scale;
    logic [3:0] eighths_scale;
    logic polarity_select;
    logic [13:0] monitored_variable_address;
  } monitor_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

endpackage

// ---- logic/variable_sample.sv ----
`timescale 1ns/10ps
`include "monitor_dac_cfg.svh"

// Registers the variable fetched from the algorithm variable space
module variable_sample (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sample
  input wire logic sample_en,
  input wire logic signed [15:0] var_data,
  output logic signed [15:0] held
);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      held <= 16'sh0000;
    end else if (sample_en) begin
      held <= var_data;
    end
  end

endmodule

// ---- logic/monitor_scaler.sv ----
`timescale 1ns/10ps
`include "monitor_dac_cfg.svh"

// Scale the held variable and map onto the converter code, registered
module monitor_scaler
  import monitor_dac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Config and data
  input wire monitor_dac_pkg::monitor_cfg_s cfg,
  input wire logic signed [15:0] value,
  output logic [11:0] code
);

  // Wide enough for full-scale input shifted by fifteen, times 4096
  logic signed [47:0] scaled;
  logic signed [47:0] mapped;
  logic [11:0] next_code;

  function automatic logic [11:0] clamp(input logic signed [47:0] v);
    if (v < 48'sd0) begin
      clamp = 12'h000;
    end else if (v > 48'sd4095) begin
      clamp = `DAC_FULL;
    end else begin
      clamp = v[11:0];
    end
  endfunction

  always_comb begin
    scaled = 48'sd0;
    mapped = 48'sd0;
    // Zero eighths selects power of two
    if (cfg.eighths_scale == 4'h0) begin
      // Enum value times two to the k, full scale 31
      scaled = (48'(value) <<< cfg.power_of_two_scale) * 48'sd4096 / 48'sd31;
    end else begin
      // Multiply by n over eight; value is Q15 per-unit
      scaled = (48'(value) * 48'(signed'({1'b0, cfg.eighths_scale}))) >>> 6;
    end
    if (cfg.polarity_select) begin
      // Unipolar, 0 pu at zero code
      mapped = scaled;
    end else begin
      mapped = (scaled >>> 1) + 48'sd2048;
    end
  end

  assign next_code = clamp(mapped);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      code <= `DAC_MID;
    end else begin
      code <= next_code;
    end
  end

endmodule

// ---- logic/monitor_dac_channel_config.sv ----
// Design decision made here: the address-and-strobe port.
`timescale 1ns/10ps
`include "monitor_dac_cfg.svh"

// What this block does
// - Fetch variable at 14-bit configured address
// - Enum mode multiplies by two to k
// - Power scale used only when eighths zero
// - Zero eighths means enum, max 31
// - Nonzero n multiplies by n/8, reset 8
// - Unipolar: 0 pu 0V, 1 pu 3V
// - Bipolar default: zero at midscale
module monitor_dac_channel_config
  import monitor_dac_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire monitor_dac_pkg::reg_req_s req,
  output logic [31:0] rdata,
  // Algorithm variable space
  output logic [13:0] monitored_variable_address,
  input wire logic signed [15:0] var_data,
  // Converter
  output logic [11:0] monitor_output_two
);

  monitor_cfg_s cfg;
  logic [13:0] watch_address;
  logic polarity_select;
  logic [3:0] eighths_scale;
  logic [3:0] power_of_two_scale;
  logic hit;
  logic write_hit;
  logic read_hit;
  logic signed [15:0] held;
  logic [11:0] code;

  // Scale and polarity fields are write-only; reserved bits read zero
  function automatic logic [31:0] readback(input logic [13:0] address);
    readback = {18'h00000, address};
  endfunction

  assign hit = (req.addr == `CFG_OFFSET);
  assign write_hit = req.wr && hit;
  assign read_hit = req.rd && hit;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watch_address <= `ADDR_RESET;
    end else if (write_hit) begin
      watch_address <= req.wdata[`ADDR_MSB:`ADDR_LSB];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      polarity_select <= `POLARITY_RESET;
    end else if (write_hit) begin
      polarity_select <= req.wdata[`POLARITY_BIT];
    end
  end

  // Eighths field, resets to unity gain
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      eighths_scale <= `EIGHTHS_RESET;
    end else if (write_hit) begin
      eighths_scale <= req.wdata[`EIGHTHS_MSB:`EIGHTHS_LSB];
    end
  end

  // Power field; cleared so enum mode never sees an unknown shift
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_of_two_scale <= `POW2_RESET;
    end else if (write_hit) begin
      power_of_two_scale <= req.wdata[`POW2_MSB:`POW2_LSB];
    end
  end

  assign cfg = {power_of_two_scale, eighths_scale, polarity_select, watch_address};

  // Only the address reads back
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else if (read_hit) begin
      rdata <= readback(watch_address);
    end else begin
      rdata <= 32'h00000000;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitored_variable_address <= `ADDR_RESET;
    end else begin
      monitored_variable_address <= watch_address;
    end
  end

  variable_sample u_sample (
    .clk(clk),
    .resetn(resetn),
    .sample_en(1'b1),
    .var_data(var_data),
    .held(held)
  );

  monitor_scaler u_scale (
    .clk(clk),
    .resetn(resetn),
    .cfg(cfg),
    .value(held),
    .code(code)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      monitor_output_two <= `DAC_MID;
    end else begin
      monitor_output_two <= code;
    end
  end

endmodule

// ---- test/monitor_dac_channel_config_sva.sv ----
`timescale 1ns/10ps
module monitor_dac_channel_config_sva
  import monitor_dac_pkg::*;
(
  // Watched ports
  input wire logic clk,
  input wire logic resetn,
  input wire monitor_dac_pkg::reg_req_s req,
  input wire logic [31:0] rdata,
  input wire logic [13:0] monitored_variable_address,
  input wire logic signed [15:0] var_data,
  input wire logic [11:0] monitor_output_two
);
  wire hit = req.addr == 12'h0F6;
  wire [11:0] o = monitor_output_two;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Seven quiet cycles cover the output latency
  sequence calm(w, v);
    req.wr && hit && req.wdata[22:14] == w ##1 (!req.wr && var_data == v) [*7];
  endsequence
  AST_ADR:
    assert property (req.wr && hit |-> ##2 monitored_variable_address == $past(req.wdata[13:0], 2)) else $error("adr");
  AST_BRD: assert property (req.rd && !hit |=> rdata == 32'h0) else $error("bad rd");
  AST_RHI: assert property (req.rd && hit |=> rdata[31:14] == 18'h0) else $error("rd hi");
  AST_BIP: assert property (calm(9'h010, 16'h0) |-> o == 12'h800) else $error("bip");
  AST_UNI: assert property (calm(9'h011, 16'h0) |-> o == 12'h0) else $error("uni");
  AST_EIG: assert property (calm(9'h1E9, 16'h4000) |-> o == 12'h400) else $error("eig");
  AST_SAT: assert property (calm(9'h01F, 16'h7FFF) |-> o == 12'hFFF) else $error("sat");
  AST_PW2: assert property (calm(9'h061, 16'h1) |-> o == 12'h421) else $error("pw2");
endmodule

// ---- test/monitor_dac_channel_config_tb.sv ----
`timescale 1ns/10ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module monitor_dac_channel_config_tb;
  import monitor_dac_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_s req = '0;
  logic signed [15:0] var_data = 16'sh4000;
  logic [31:0] rdata;
  logic [13:0] adr;
  logic [11:0] code;
  int n_errors = 0;
  int check_count = 0;
  // Config word, variable, code
  logic [59:0] rows [8] = '{60'h007A41234000400, 60'h0007C0007FFFFFF, 60'h001840000001421, 60'h000780008000000,
    60'hFF843FFF0000800, 60'h000440000000000, 60'h007840007FFFFFF, 60'h00000000FFFF7BE};
  always #4 clk = ~clk;
  monitor_dac_channel_config dut_u (.clk, .resetn, .req, .rdata, .monitored_variable_address(adr), .var_data,
    .monitor_output_two(code));
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [15:0] v);
    @(posedge clk);
    req <= '{w, !w, a, d};
    var_data <= v;
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic apply(input logic [59:0] r);
    acc(1'b1, 12'h0F6, r[59:28], r[27:12]);
    repeat (8) @(posedge clk);
    #1;
    `CHK("code", r[11:0], code)
    `CHK("adr", r[41:28], adr)
    acc(1'b0, 12'h0F6, 32'h0, r[27:12]);
    `CHK("rd", {18'h0, r[41:28]}, rdata)
  endtask
  task tally_and_finish;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHK("rst", 12'h800, code)
    repeat (8) @(posedge clk);
    #1;
    `CHK("dflt", 12'hC00, code)
    foreach (rows[i]) apply(rows[i]);
    for (int k = 1; k < 16; k++) apply({13'h0, k[3:0], 1'b1, 14'h0, 16'h4000, k[3:0], 8'h0});
    acc(1'b1, 12'h0F7, 32'h1555, 16'h0);
    acc(1'b0, 12'h0F7, 32'h0, 16'h0);
    `CHK("bad", 46'h0, {rdata, adr})
    // Reset in mid-run must restore every field
    acc(1'b1, 12'h0F6, 32'h00002AAA, 16'h4000);
    repeat (3) @(posedge clk);
    #1;
    `CHK("enum sat", 12'hFFF, code)
    `CHK("adr pre", 14'h2AAA, adr)
    @(posedge clk);
    resetn <= 1'b0;
    #1;
    `CHK("rst mid", 12'h800, code)
    `CHK("adr rst", 14'h0, adr)
    @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("dflt mid", 12'hC00, code)
    acc(1'b0, 12'h0F6, 32'h0, 16'h4000);
    `CHK("rd rst", 32'h0, rdata)
    tally_and_finish;
  end
  // Watchdog
  initial begin
    #100000;
    n_errors++;
    tally_and_finish;
  end
endmodule
bind monitor_dac_channel_config monitor_dac_channel_config_sva chk_u (.clk, .resetn, .req, .rdata,
  .monitored_variable_address, .var_data, .monitor_output_two);
